// *** src/swb_pkg.sv ***
// Shared constants for the subtract-with-borrow arithmetic unit.
// Assumes an 8-bit core datapath and an APB register port.
package swb_pkg;

   localparam int unsigned DATA_W = 8;

   // Operations issued by the instruction decoder
   typedef enum logic [2:0] {
      OP_SUB_AI  = 3'h0,
      OP_SUB_AM  = 3'h1,
      OP_SUB_MA  = 3'h2,
      OP_SUBC_AM = 3'h3,
      OP_SUBC_MA = 3'h4,
      OP_SUBC_A  = 3'h5,
      OP_SUBC_M  = 3'h6,
      OP_NONE    = 3'h7
   } swb_op_t;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'h1,
      ST_FETCH = 4'h2,
      ST_EXEC  = 4'h4,
      ST_DONE  = 4'h8
   } swb_state_t;

   // Register byte addresses
   localparam logic [11:0] ADDR_WREG   = 12'h000;
   localparam logic [11:0] ADDR_FLAGS  = 12'h004;
   localparam logic [11:0] ADDR_STATUS = 12'h008;

   // Flag register fields
   localparam int unsigned FLAG_Z  = 0;
   localparam int unsigned FLAG_C  = 1;
   localparam int unsigned FLAG_AC = 2;
   localparam int unsigned FLAG_OV = 3;
   localparam int unsigned FLAG_W  = 4;

   // Status register fields
   localparam int unsigned STAT_BUSY    = 0;
   localparam int unsigned STAT_ILLEGAL = 1;
   localparam int unsigned STAT_CNT_LO  = 8;
   localparam int unsigned CNT_W        = 8;

   localparam logic [7:0]        WREG_RST  = 8'h00;
   localparam logic [FLAG_W-1:0] FLAGS_RST = 4'h0;

endpackage

// *** src/swb_sub8.sv ***
// Two's-complement subtractor with borrow, half-borrow and overflow outputs.
// Purely combinational; the caller registers what it needs.
`timescale 1ns/100ps
module swb_sub8
   import swb_pkg::*;
#(
   parameter int unsigned W = DATA_W
) (
   input  wire logic [W-1:0] minuend,
   input  wire logic [W-1:0] subtrahend,
   input  wire logic         borrow_in,
   output logic      [W-1:0] diff,
   output logic              borrow_out,
   output logic              half_borrow,
   output logic              ovf,
   output logic              zero
);

   logic [W:0] sum;
   logic [4:0] low;
   logic       cin;

   // Add the complement of the subtrahend; a carry out means no borrow
   assign cin         = ~borrow_in;
   assign sum         = {1'b0, minuend} + {1'b0, ~subtrahend} + {{W{1'b0}}, cin};
   assign low         = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + {4'h0, cin};
   assign diff        = sum[W-1:0];
   assign borrow_out  = ~sum[W];
   assign half_borrow = ~low[4];
   assign ovf         = (minuend[W-1] != subtrahend[W-1]) && (diff[W-1] != minuend[W-1]);
   assign zero        = (diff == '0);

endmodule

// *** src/swb_dec.sv ***
// Operation decoder: turns an operation code into datapath steering.
// Assumes the code is stable while the unit holds it.
`timescale 1ns/100ps
module swb_dec
   import swb_pkg::*;
(
   input  wire logic [2:0] op,
   output logic            needs_mem,
   output logic            dst_mem,
   output logic            use_borrow,
   output logic            zero_sub,
   output logic            use_imm,
   output logic            legal
);

   always_comb begin
      needs_mem  = 1'b0;
      dst_mem    = 1'b0;
      use_borrow = 1'b0;
      zero_sub   = 1'b0;
      use_imm    = 1'b0;
      legal      = 1'b1;
      case (swb_op_t'(op))
         OP_SUB_AI: begin
            use_imm = 1'b1;
         end
         OP_SUB_AM: begin
            needs_mem = 1'b1;
         end
         OP_SUB_MA: begin
            needs_mem = 1'b1;
            dst_mem   = 1'b1;
         end
         OP_SUBC_AM: begin
            needs_mem  = 1'b1;
            use_borrow = 1'b1;
         end
         OP_SUBC_MA: begin
            needs_mem  = 1'b1;
            dst_mem    = 1'b1;
            use_borrow = 1'b1;
         end
         OP_SUBC_A: begin
            use_borrow = 1'b1;
            zero_sub   = 1'b1;
         end
         OP_SUBC_M: begin
            needs_mem  = 1'b1;
            dst_mem    = 1'b1;
            use_borrow = 1'b1;
            zero_sub   = 1'b1;
         end
         default: begin
            legal = 1'b0;
         end
      endcase
   end

endmodule

// *** src/swb_alu.sv ***
// Subtract unit of the core's arithmetic block, with an APB register port.
// Assumes data memory answers a read one cycle after mem_rd_en.
// Summary of operation
// (RULE1) Immediate subtract: working register minus literal
// (RULE2) Memory source: working register minus memory byte
// (RULE3) Memory destination: memory minus working register
// (RULE4) Subtract by adding two's complement
// (RULE5) Borrow subtract, memory source, into working register
// (RULE6) Borrow subtract, memory destination, back to memory
// (RULE7) Working register minus borrow only
// (RULE8) Memory byte minus borrow only
// (RULE9) Update zero, borrow, half-borrow, overflow flags only
// (RULE10) Borrow from bit 7; half-borrow from nibble
`timescale 1ns/100ps
module swb_alu
   import swb_pkg::*;
#(
   parameter int unsigned ADDR_W = 8
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              op_valid,
   input  wire logic [2:0]        op_code,
   input  wire logic [DATA_W-1:0] op_imm,
   input  wire logic [ADDR_W-1:0] op_addr,
   output logic                   op_ready,
   output logic                   op_done,
   output logic      [ADDR_W-1:0] mem_addr,
   output logic                   mem_rd_en,
   input  wire logic [DATA_W-1:0] mem_rd_data,
   output logic                   mem_wr_en,
   output logic      [DATA_W-1:0] mem_wr_data,
   output logic      [DATA_W-1:0] working_register,
   output logic      [FLAG_W-1:0] flags
);

   swb_state_t        state_q;
   swb_state_t        state_d;
   logic [2:0]        op_q;
   logic [DATA_W-1:0] imm_q;
   logic [ADDR_W-1:0] addr_q;
   logic [DATA_W-1:0] wreg_q;
   logic [FLAG_W-1:0] flags_q;
   logic              mem_wr_en_q;
   logic [DATA_W-1:0] mem_wr_data_q;
   logic              done_q;
   logic              illegal_q;
   logic [CNT_W-1:0]  cnt_q;
   logic [31:0]       prdata_q;
   logic              needs_mem, dst_mem, use_borrow, zero_sub, use_imm, legal;
   logic [DATA_W-1:0] operand_b;
   logic [DATA_W-1:0] minuend;
   logic [DATA_W-1:0] subtrahend;
   logic              borrow_in;
   logic [DATA_W-1:0] diff;
   logic              borrow_out, half_borrow, ovf, zero;
   logic              take_op, exec, apb_setup, apb_wr, mapped;

   ////////////////////////////////////////////////////////////////////////////
   // Operand steering

   swb_dec u_dec (
      .op         (op_q),
      .needs_mem  (needs_mem),
      .dst_mem    (dst_mem),
      .use_borrow (use_borrow),
      .zero_sub   (zero_sub),
      .use_imm    (use_imm),
      .legal      (legal)
   );

   assign operand_b  = use_imm ? imm_q : mem_rd_data;
   assign minuend    = dst_mem ? mem_rd_data : wreg_q; // RULE3 RULE6 RULE8
   assign subtrahend = zero_sub ? '0 : (dst_mem ? wreg_q : operand_b); // RULE1 RULE2 RULE7
   assign borrow_in  = use_borrow & flags_q[FLAG_C]; // RULE5 RULE6 RULE7 RULE8

   // RULE4
   swb_sub8 #(
      .W (DATA_W)
   ) u_sub (
      .minuend     (minuend),
      .subtrahend  (subtrahend),
      .borrow_in   (borrow_in),
      .diff        (diff),
      .borrow_out  (borrow_out),
      .half_borrow (half_borrow),
      .ovf         (ovf),
      .zero        (zero)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Sequencing

   assign op_ready = (state_q == ST_IDLE);
   assign take_op  = op_ready & op_valid;
   assign exec     = (state_q == ST_EXEC);

   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (take_op) begin
               state_d = ST_FETCH;
            end
         end
         ST_FETCH: begin
            state_d = ST_EXEC;
         end
         ST_EXEC: begin
            state_d = ST_DONE;
         end
         ST_DONE: begin
            state_d = ST_IDLE;
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         op_q   <= OP_NONE;
         imm_q  <= '0;
         addr_q <= '0;
      end else if (take_op) begin
         op_q   <= op_code;
         imm_q  <= op_imm;
         addr_q <= op_addr;
      end
   end

   // Only operations with a memory operand issue a read; the others keep the bus quiet
   assign mem_rd_en = (state_q == ST_FETCH) & needs_mem;
   assign mem_addr  = addr_q;

   ////////////////////////////////////////////////////////////////////////////
   // Result write-back; hardware beats a same-cycle software write

   assign apb_setup = psel & ~penable;
   assign apb_wr    = psel & penable & pwrite;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wreg_q <= WREG_RST;
      end else if (exec && legal && !dst_mem) begin
         wreg_q <= diff; // RULE1 RULE2 RULE5 RULE7
      end else if (apb_wr && paddr == ADDR_WREG) begin
         wreg_q <= pwdata[DATA_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_q <= FLAGS_RST;
      end else if (exec && legal) begin
         flags_q[FLAG_Z]  <= zero; // RULE9
         flags_q[FLAG_C]  <= borrow_out; // RULE10
         flags_q[FLAG_AC] <= half_borrow; // RULE10
         flags_q[FLAG_OV] <= ovf; // RULE9
      end else if (apb_wr && paddr == ADDR_FLAGS) begin
         flags_q <= pwdata[FLAG_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_wr_en_q   <= 1'b0;
         mem_wr_data_q <= '0;
      end else begin
         mem_wr_en_q <= exec & legal & dst_mem;
         if (exec && legal && dst_mem) begin
            mem_wr_data_q <= diff; // RULE3 RULE6 RULE8
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_q <= 1'b0;
      end else begin
         done_q <= exec;
      end
   end

   // Counter wraps; it is a coarse activity indicator only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= '0;
      end else if (exec && legal) begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   // Sticky; a new illegal code wins over a same-cycle clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         illegal_q <= 1'b0;
      end else if (exec && !legal) begin
         illegal_q <= 1'b1;
      end else if (apb_wr && paddr == ADDR_STATUS && pwdata[STAT_ILLEGAL]) begin
         illegal_q <= 1'b0;
      end
   end

   assign op_done          = done_q;
   assign mem_wr_en        = mem_wr_en_q;
   assign mem_wr_data      = mem_wr_data_q;
   assign working_register = wreg_q;
   assign flags            = flags_q;

   ////////////////////////////////////////////////////////////////////////////
   // APB slave: zero wait states, read data captured in the setup cycle

   assign mapped  = (paddr == ADDR_WREG) || (paddr == ADDR_FLAGS) || (paddr == ADDR_STATUS);
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign prdata  = prdata_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= '0;
      end else if (apb_setup) begin
         prdata_q <= '0;
         if (paddr == ADDR_WREG) begin
            prdata_q[DATA_W-1:0] <= wreg_q;
         end else if (paddr == ADDR_FLAGS) begin
            prdata_q[FLAG_W-1:0] <= flags_q;
         end else if (paddr == ADDR_STATUS) begin
            prdata_q[STAT_BUSY]                       <= ~op_ready;
            prdata_q[STAT_ILLEGAL]                    <= illegal_q;
            prdata_q[STAT_CNT_LO +: CNT_W]            <= cnt_q;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   sequence s_mem_op;
      state_q == ST_FETCH && mem_rd_en ##1 state_q == ST_EXEC;
   endsequence

   sequence s_finish;
      state_q == ST_DONE && op_done ##1 state_q == ST_IDLE;
   endsequence

   property p_op_flow;
      @(posedge pclk) disable iff (!presetn)
         take_op |=> s_mem_op or (state_q == ST_FETCH ##1 state_q == ST_EXEC ##1 s_finish);
   endproperty

   chk_op_flow: assert property (p_op_flow) // RULE2
      else $error("operation did not step through fetch and execute");

   chk_imm_sub: assert property ( // RULE1
      @(posedge pclk) disable iff (!presetn)
         exec && swb_op_t'(op_q) == OP_SUB_AI |=> wreg_q == 8'($past(wreg_q) - $past(imm_q)))
      else $error("immediate subtract result wrong");

   chk_mem_src: assert property ( // RULE2
      @(posedge pclk) disable iff (!presetn)
         exec && swb_op_t'(op_q) == OP_SUB_AM |=> wreg_q == 8'($past(wreg_q) - $past(mem_rd_data)))
      else $error("memory source subtract result wrong");

   chk_mem_dst: assert property ( // RULE3
      @(posedge pclk) disable iff (!presetn)
         exec && swb_op_t'(op_q) == OP_SUB_MA
         |=> mem_wr_en && mem_wr_data == 8'($past(mem_rd_data) - $past(wreg_q))
             && $stable(wreg_q) ##1 !mem_wr_en)
      else $error("memory destination subtract wrong");

   chk_twos_comp: assert property ( // RULE4
      @(posedge pclk) disable iff (!presetn)
         exec && legal |-> {borrow_out, diff}
                           == 9'({1'b0, minuend} - {1'b0, subtrahend} - {8'h00, borrow_in}))
      else $error("difference is not the complement sum");

   chk_subc_src: assert property ( // RULE5
      @(posedge pclk) disable iff (!presetn)
         exec && swb_op_t'(op_q) == OP_SUBC_AM
         |=> wreg_q == 8'($past(wreg_q) - $past(mem_rd_data) - {7'h00, $past(flags_q[FLAG_C])}))
      else $error("borrow subtract into working register wrong");

   chk_subc_dst: assert property ( // RULE6
      @(posedge pclk) disable iff (!presetn)
         exec && swb_op_t'(op_q) == OP_SUBC_MA
         |=> mem_wr_data == 8'($past(mem_rd_data) - $past(wreg_q) - {7'h00, $past(flags_q[FLAG_C])}))
      else $error("borrow subtract into memory wrong");

   chk_subc_acc: assert property ( // RULE7
      @(posedge pclk) disable iff (!presetn)
         exec && swb_op_t'(op_q) == OP_SUBC_A
         |=> wreg_q == 8'($past(wreg_q) - {7'h00, $past(flags_q[FLAG_C])}) && !mem_wr_en)
      else $error("borrow-only subtract on working register wrong");

   chk_subc_mem: assert property ( // RULE8
      @(posedge pclk) disable iff (!presetn)
         exec && swb_op_t'(op_q) == OP_SUBC_M
         |=> mem_wr_en && mem_wr_data == 8'($past(mem_rd_data) - {7'h00, $past(flags_q[FLAG_C])}))
      else $error("borrow-only subtract on memory wrong");

   chk_zero_flag: assert property ( // RULE9
      @(posedge pclk) disable iff (!presetn)
         exec && legal |=> flags_q[FLAG_Z] == ($past(diff) == 8'h00)
                           && flags_q[FLAG_OV] == $past(ovf))
      else $error("zero or overflow flag wrong");

   chk_flags_hold: assert property ( // RULE9
      @(posedge pclk) disable iff (!presetn)
         !exec && !apb_wr |=> $stable(flags_q))
      else $error("flags changed outside a subtract");

   chk_borrow_bits: assert property ( // RULE10
      @(posedge pclk) disable iff (!presetn)
         exec && legal
         |=> flags_q[FLAG_C] == ({1'b0, $past(minuend)}
                                 < 9'({1'b0, $past(subtrahend)} + {8'h00, $past(borrow_in)}))
             && flags_q[FLAG_AC] == ({1'b0, $past(minuend[3:0])}
                                 < 5'({1'b0, $past(subtrahend[3:0])} + {4'h0, $past(borrow_in)})))
      else $error("borrow or half-borrow flag wrong");

endmodule

// *** tb/swb_mem_model.sv ***
// Behavioural data memory facing the subtract unit's memory port.
// Assumes the unit asks for a read one cycle before it samples the data.
`timescale 1ns/100ps
module swb_mem_model
   import swb_pkg::*;
#(
   parameter int unsigned ADDR_W = 8
) (
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic              rd_en,
   output logic      [DATA_W-1:0] rd_data,
   input  wire logic              wr_en,
   input  wire logic [DATA_W-1:0] wr_data
);
   logic [DATA_W-1:0] mem_q [2**ADDR_W];
   logic [DATA_W-1:0] data_q;
   logic              valid_q;

   // Outside the answer cycle the bus shows the inverse, so a mistimed sample shows up
   assign rd_data = valid_q ? data_q : ~data_q;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         valid_q <= 1'b0;
         data_q  <= 8'h00;
      end else begin
         valid_q <= (rd_en === 1'b1);
         if (rd_en === 1'b1) begin
            data_q <= mem_q[addr];
         end
      end
   end

   always @(posedge clk) begin
      if (wr_en === 1'b1) begin
         mem_q[addr] <= wr_data;
      end
   end
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the subtract unit: APB registers and operation port.
// Assumes the memory model answers the unit's memory port.
`timescale 1ns/100ps
module testbench
   import swb_pkg::*;
;
   localparam int unsigned ADDR_W = 8;
   logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0]       paddr;
   logic [31:0]       pwdata, prdata;
   logic              op_valid, op_ready, op_done, mem_rd_en, mem_wr_en;
   logic [2:0]        op_code;
   logic [7:0]        op_imm, mem_rd_data, mem_wr_data, working_register;
   logic [ADDR_W-1:0] op_addr, mem_addr;
   logic [3:0]        flags, exp_flg;
   logic [7:0]        exp_acc;
   int                n_fail, n_compared, n_cycles;

   swb_alu #(.ADDR_W(ADDR_W)) swb_alu_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .op_valid(op_valid), .op_code(op_code),
      .op_imm(op_imm), .op_addr(op_addr), .op_ready(op_ready), .op_done(op_done),
      .mem_addr(mem_addr), .mem_rd_en(mem_rd_en), .mem_rd_data(mem_rd_data),
      .mem_wr_en(mem_wr_en), .mem_wr_data(mem_wr_data),
      .working_register(working_register), .flags(flags));
   swb_mem_model #(.ADDR_W(ADDR_W)) swb_mem_model_i (.clk(pclk), .rst_n(presetn),
      .addr(mem_addr), .rd_en(mem_rd_en), .rd_data(mem_rd_data), .wr_en(mem_wr_en),
      .wr_data(mem_wr_data));

   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      $display("compared %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // A hung handshake would otherwise stall the run for ever
   always @(posedge pclk) begin
      n_cycles <= n_cycles + 1;
      if (n_cycles == 20000) begin
         n_fail++;
         $display("run took too long");
         test_done();
      end
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Wait for pready; if it never rises, only the bench timeout ends this wait
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic set_regs(input logic [7:0] acc, input logic [3:0] f);
      logic [31:0] q;
      logic        e;
      apb(1'b1, ADDR_WREG, {24'h000000, acc}, q, e);
      apb(1'b1, ADDR_FLAGS, {28'h0000000, f}, q, e);
      exp_acc = acc;
      exp_flg = f;
   endtask

   // Result of minuend - subtrahend - borrow as {flags, difference}
   function automatic logic [11:0] ref_sub(input logic [7:0] m, input logic [7:0] s,
                                            input logic b);
      logic [8:0] d;
      logic [4:0] h;
      logic [3:0] f;
      d = {1'b0, m} - {1'b0, s} - {8'h00, b};
      h = {1'b0, m[3:0]} - {1'b0, s[3:0]} - {4'h0, b};
      f[FLAG_Z]  = (d[7:0] == 8'h00);
      f[FLAG_C]  = d[8];
      f[FLAG_AC] = h[4];
      f[FLAG_OV] = (m[7] != s[7]) && (d[7] != m[7]);
      return {f, d[7:0]};
   endfunction

   task automatic run_op(input swb_op_t op, input logic [7:0] imm, input logic [7:0] a,
                         input logic [7:0] mv);
      logic [7:0]  s;
      logic [11:0] r;
      logic        dst_m;
      int          k;
      dst_m = (op == OP_SUB_MA) || (op == OP_SUBC_MA) || (op == OP_SUBC_M);
      swb_mem_model_i.mem_q[a] = mv;
      case (op)
         OP_SUB_AI:             s = imm;
         OP_SUB_AM, OP_SUBC_AM: s = mv;
         OP_SUB_MA, OP_SUBC_MA: s = exp_acc;
         default:               s = 8'h00;
      endcase
      r = ref_sub(dst_m ? mv : exp_acc, s, (op >= OP_SUBC_AM) && exp_flg[FLAG_C]);
      if (op == OP_NONE) begin
         r = {exp_flg, exp_acc};
      end
      @(posedge pclk);
      op_valid <= 1'b1;
      op_code  <= op;
      op_imm   <= imm;
      op_addr  <= a;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (op_ready !== 1'b1 && k < 20);
      op_valid <= 1'b0;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (op_done !== 1'b1 && k < 20);
      chk("done latency", 3, k);
      if (dst_m) begin
         chk("mem_wr_data", r[7:0], mem_wr_data);
         chk("mem_wr_en", 1, mem_wr_en);
      end else begin
         exp_acc = r[7:0];
      end
      exp_flg = r[11:8];
      chk("working_register", exp_acc, working_register);
      chk("flags", exp_flg, flags);
      @(posedge pclk);
      chk("memory", dst_m ? r[7:0] : mv, swb_mem_model_i.mem_q[a]);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      logic [31:0] q;
      logic        e;
      apb(1'b0, ADDR_WREG, 32'h0, q, e);
      chk("wreg reset", 32'h0, q);
      apb(1'b0, ADDR_FLAGS, 32'h0, q, e);
      chk("flags reset", 32'h0, q);
      apb(1'b0, ADDR_STATUS, 32'h0, q, e);
      chk("status reset", 32'h0, q);
      apb(1'b1, ADDR_WREG, 32'h1a5, q, e);
      apb(1'b1, ADDR_FLAGS, 32'hff, q, e);
      apb(1'b0, ADDR_WREG, 32'h0, q, e);
      chk("wreg readback", 32'ha5, q);
      apb(1'b0, ADDR_FLAGS, 32'h0, q, e);
      chk("flags readback", 32'hf, q);
      chk("flags port", 32'hf, flags);
      apb(1'b0, 12'h00c, 32'h0, q, e);
      chk("unmapped error", 1, e);
      chk("unmapped data", 32'h0, q);
      exp_acc = 8'ha5;
      exp_flg = 4'hf;
      $display("test regs finished");
   endtask

   task automatic t_imm();
      logic [15:0] v [5] = '{16'h0001, 16'h1001, 16'h8001, 16'h5555, 16'h7fff};
      for (int i = 0; i < 5; i++) begin
         set_regs(v[i][15:8], 4'hf);
         run_op(OP_SUB_AI, v[i][7:0], 8'h00, 8'h33);
      end
      $display("test immediate finished");
   endtask

   task automatic t_mem();
      for (int op = 1; op < 7; op++) begin
         for (int b = 0; b < 2; b++) begin
            set_regs(b ? 8'h80 : 8'h10, b ? 4'h2 : 4'hd);
            run_op(swb_op_t'(op), 8'h00, {op[2:0], b[0], 4'h0},
                   b ? 8'h7f : 8'h10);
         end
      end
      set_regs(8'h00, 4'h2);
      run_op(OP_SUBC_A, 8'h00, 8'h00, 8'h00);
      run_op(OP_SUBC_A, 8'h00, 8'h00, 8'h00);
      $display("test memory finished");
   endtask

   task automatic t_illegal();
      logic [31:0] q;
      logic        e;
      set_regs(8'h5a, 4'h6);
      run_op(OP_NONE, 8'h01, 8'hff, 8'h44);
      apb(1'b0, ADDR_STATUS, 32'h0, q, e);
      chk("illegal flag", 1, q[STAT_ILLEGAL]);
      chk("busy idle", 0, q[STAT_BUSY]);
      chk("op count", 32'h13, {24'h000000, q[STAT_CNT_LO +: CNT_W]});
      apb(1'b1, ADDR_STATUS, 32'h2, q, e);
      apb(1'b0, ADDR_STATUS, 32'h0, q, e);
      chk("illegal cleared", 0, q[STAT_ILLEGAL]);
      $display("test illegal finished");
   endtask

   initial begin
      {presetn, psel, penable, pwrite, op_valid} = 5'h00;
      {paddr, pwdata, op_code, op_imm, op_addr} = '0;
      {n_fail, n_compared, n_cycles} = '0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_imm();
      t_mem();
      t_illegal();
      test_done();
   end
endmodule
